/* test/cbmc_proc_model.sv */
// processor-side model: watchdog hold and system reset lines
`timescale 1ns/1ns
module cbmc_proc_model (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_processor_reset_out_n,
   input wire logic [1:0] i_fail_mode,
   input wire logic i_slow,
   output logic o_watchdog_hold_input,
   output logic o_system_reset_n
);
   logic [7:0] cnt_ff = 8'h00;
   logic done;
   // ---------------------------------------------------------------
   // enumeration timer, restarted while the processor is held in reset
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_reset || !i_processor_reset_out_n) begin
         cnt_ff <= 8'h00;
      end else if (cnt_ff != 8'hFF) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
   // slow answer models a long enumeration on a busy host
   assign done = (cnt_ff >= (i_slow ? 8'h0C : 8'h02));
   // hold stays high unless enumeration is commanded to fail
   assign o_watchdog_hold_input = !(done && i_fail_mode == 2'h1);
   // a brown-out pulls the system reset low once the processor runs
   assign o_system_reset_n = !(done && i_fail_mode == 2'h2);
endmodule

/* test/cbmc_test.sv */
// self-checking bench for the charger boot mode control block
`timescale 1ns/1ns
module cbmc_test;
   import cbmc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, slow = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, rdat;
   logic [1:0] fmode = 2'h0;
   logic bv = 1'b0, idl = 1'b0, ser = 1'b0, strap = 1'b0, son = 1'b0, sbon = 1'b0;
   logic bmin = 1'b0, cold = 1'b1, pud = 1'b0, oirq = 1'b0, chg = 1'b0, core = 1'b0;
   logic inr = 1'b1, dcold = 1'b0, pre = 1'b0;
   wire logic [31:0] rdo;
   wire logic wt, watchdog_hold_input, srst_n, pwr, prst_n, irq, usb, ind, trk, pass, iso, ctim, ptim;
   wire logic lim, bias;
   wire logic [3:0] code;
   wire logic [9:0] ext;
   int n_errors = 0;
   int tests_run = 0;
   always #2 clk = !clk;
   cbmc_proc_model i_proc (.i_core_clk(clk), .i_reset(rst), .i_processor_reset_out_n(prst_n),
      .i_fail_mode(fmode), .i_slow(slow), .o_watchdog_hold_input(watchdog_hold_input),
      .o_system_reset_n(srst_n));
   cbmc_top i_dut (.i_core_clk(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdo), .o_avs_waitrequest(wt),
      .i_bus_valid(bv), .i_identity_sense_line(idl), .i_serial_path(ser),
      .i_mode_strap(strap), .i_supply_above_on(son), .i_supply_above_battery_on(sbon),
      .i_battery_above_min(bmin), .i_cold_start(cold), .i_powerup_done(pud),
      .i_watchdog_hold_input(watchdog_hold_input), .i_system_reset_n(srst_n), .i_other_irq(oirq),
      .i_charger_input(chg), .i_core_rail_ready(core), .i_thermistor_in_range(inr),
      .i_die_cold(dcold), .i_precharge_active(pre), .o_power_on(pwr),
      .o_processor_reset_out_n(prst_n), .o_irq(irq), .o_usb_supplies_en(usb),
      .o_charge_indicator(ind), .o_trickle_en(trk), .o_pass_pair_full_on(pass),
      .o_battery_isolation_closed(iso), .o_charger_timer_en(ctim),
      .o_precharge_timer_en(ptim), .o_power_limiter_en(lim), .o_charge_current_code(code),
      .o_ext_current_ma(ext), .o_thermistor_bias_out(bias));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one avalon access; the request stands until waitrequest is seen low
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wt !== 1'b0 && n < 20);
      rdat = rdo;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 20) chk(32'h1, 32'h0);
   endtask
   task automatic sb(input int b, input logic v);
      acc(1'b0, CBMC_ADDR_STAT, 32'h0);
      chk(32'(rdat[b]), 32'(v));
   endtask
   // poll the state field under a bounded count of reads
   task automatic st(input logic [7:0] s);
      int n;
      n = 0;
      do begin
         acc(1'b0, CBMC_ADDR_STAT, 32'h0);
         n++;
      end while (rdat[15:8] !== s && n < 30);
      chk(32'(rdat[15:8]), 32'(s));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // full restart keeps scenarios independent of each other
   task automatic rs();
      @(posedge clk);
      rst <= 1'b1;
      {bv, pud, son, bmin, oirq, chg, core, dcold, pre} <= 9'h000;
      inr <= 1'b1;
      fmode <= 2'h0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic att(input logic id, input logic s, input logic m);
      @(posedge clk);
      {idl, ser, strap} <= {id, s, m};
      bv <= 1'b1;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      acc(1'b0, CBMC_ADDR_CTRL, 32'h0);
      chk(rdat, 32'(CTRL_RESET));
      acc(1'b0, CBMC_ADDR_CHG, 32'h0);
      chk(rdat, 32'(ICODE_LOWEST));
      acc(1'b1, 4'hC, 32'hFFFF_FFFF);
      acc(1'b0, 4'hC, 32'h0);
      chk(rdat, 32'h0);
      st(ST_IDLE);
      $display("done regs");
   endtask
   task automatic t_fact();
      rs();
      att(1'b1, 1'b1, 1'b0);
      st(ST_FACTORY);
      chk(32'({pass, iso, trk, ctim, ptim, lim}), 32'h20);
      acc(1'b1, CBMC_ADDR_CTRL, 32'h1 << CTRL_SW_CHARGE);
      cyc(2);
      sb(STAT_FACTORY, 1'b0);
      rs();
      att(1'b1, 1'b0, 1'b0);
      st(ST_FACTORY);
      chk(32'({pwr, ctim, ptim, lim}), 32'hA);
      chk(32'(ext), 32'(EXT_MA_FACTORY));
      acc(1'b1, CBMC_ADDR_CHG, 32'h5);
      acc(1'b0, CBMC_ADDR_CHG, 32'h0);
      chk(rdat, 32'(ICODE_LOWEST));
      acc(1'b1, CBMC_ADDR_CTRL, 32'h1 << CTRL_OVERRIDE);
      acc(1'b1, CBMC_ADDR_CHG, 32'h5);
      acc(1'b0, CBMC_ADDR_CHG, 32'h0);
      chk(rdat, 32'h5);
      $display("done factory");
   endtask
   task automatic t_lpb();
      rs();
      att(1'b0, 1'b1, 1'b1);
      st(ST_POWERUP);
      sb(STAT_FACTORY, 1'b0);
      sb(STAT_BOOT_FLAG, 1'b1);
      chk(32'({code, usb, ind}), 32'({ICODE_LOWEST, 2'b10}));
      pud <= 1'b1;
      st(ST_WATCHDOG);
      chk(32'({code, irq, prst_n}), 32'({ICODE_STEPPED, 2'b11}));
      {chg, inr, pre} <= 3'b101;
      cyc(3);
      chk(32'({ext, iso}), 32'({EXT_MA_LPB, 1'b0}));
      {chg, inr, pre} <= 3'b010;
      cyc(3);
      sb(STAT_CHG_ACTIVE, 1'b0);
      acc(1'b1, CBMC_ADDR_CTRL, 32'h1 << CTRL_BOOT_ACK);
      cyc(2);
      chk(32'({ind, trk}), 32'h3);
      sb(STAT_CHG_ACTIVE, 1'b1);
      chk(32'(iso), 32'h0);
      bmin <= 1'b1;
      cyc(3);
      chk(32'(iso), 32'h1);
      son <= 1'b1;
      cyc(3);
      sb(STAT_BOOT_FLAG, 1'b0);
      sb(STAT_BOOT_IRQ, 1'b1);
      acc(1'b1, CBMC_ADDR_CTRL, 32'h24);
      cyc(2);
      sb(STAT_BOOT_IRQ, 1'b0);
      st(ST_ON);
      oirq <= 1'b1;
      cyc(3);
      chk(32'(irq), 32'h1);
      $display("done low power boot");
   endtask
   // failed enumeration, then a brown-out, each during the watchdog phase
   task automatic t_fail();
      for (int m = 1; m <= 2; m++) begin
         rs();
         slow <= (m == 2);
         att(1'b0, 1'b1, 1'b1);
         pud <= 1'b1;
         st(ST_WATCHDOG);
         fmode <= 2'(m);
         st(ST_SHUTDOWN);
         sb(STAT_BOOT_FLAG, 1'b0);
         chk(32'(pwr), 32'h0);
      end
      $display("done boot failure");
   endtask
   // grounded strap, then strapped single path from cold and from warm start
   task automatic t_norm();
      for (int m = 0; m < 3; m++) begin
         rs();
         {sbon, cold, oirq} <= {m == 2, m != 2, m != 0};
         att(1'b0, m == 0, m != 0);
         pud <= 1'b1;
         if (m != 2) st(ST_TRICKLE);
         sbon <= 1'b1;
         st(ST_ON);
         sb(STAT_BOOT_FLAG, 1'b0);
         chk(32'(pwr), 32'h1);
      end
      $display("done normal boot");
   endtask
   task automatic t_therm();
      rs();
      {chg, core} <= 2'b11;
      cyc(3);
      chk(32'(bias), 32'h1);
      inr <= 1'b0;
      cyc(3);
      sb(STAT_THERM_WAIT, 1'b1);
      chk(32'({ext, iso}), 32'({EXT_MA_ZERO, 1'b1}));
      pre <= 1'b1;
      cyc(3);
      chk(32'({ext, iso, trk}), 32'({EXT_MA_CHARGER, 2'b00}));
      {pre, inr} <= 2'b01;
      cyc(3);
      sb(STAT_THERM_WAIT, 1'b0);
      acc(1'b1, CBMC_ADDR_CTRL, 32'h1 << CTRL_THERM_DIS);
      inr <= 1'b0;
      cyc(3);
      chk(32'(bias), 32'h0);
      sb(STAT_THERM_WAIT, 1'b0);
      acc(1'b1, CBMC_ADDR_CTRL, 32'h18);
      dcold <= 1'b1;
      cyc(3);
      chk(32'(bias), 32'h1);
      sb(STAT_THERM_WAIT, 1'b1);
      $display("done thermal");
   endtask
   // ---------------------------------------------------------------
   // sequence, verdict and watchdog
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_fact();
      t_lpb();
      t_fail();
      t_norm();
      t_therm();
      end_of_test();
   end
   // the scenarios need a few hundred cycles; this limit leaves ample slack
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
endmodule

/* verilog/cbmc_pkg.sv */
// constants and types shared by the charger boot mode control block
package cbmc_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [3:0] CBMC_ADDR_CTRL = 4'h0;
   localparam logic [3:0] CBMC_ADDR_STAT = 4'h4;
   localparam logic [3:0] CBMC_ADDR_CHG = 4'h8;
   // control register fields
   localparam int CTRL_OVERRIDE = 0;
   localparam int CTRL_SW_CHARGE = 1;
   localparam int CTRL_BOOT_ACK = 2;
   localparam int CTRL_THERM_DIS = 3;
   localparam int CTRL_BIAS_EN = 4;
   localparam int CTRL_IRQ_CLR = 5;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   // status register fields
   localparam int STAT_FACTORY = 0;
   localparam int STAT_BOOT_FLAG = 1;
   localparam int STAT_BOOT_IRQ = 2;
   localparam int STAT_CHG_ACTIVE = 3;
   localparam int STAT_THERM_WAIT = 4;
   localparam int STAT_STATE_LSB = 8;
   // ---------------------------------------------------------------
   // charge current codes and currents
   // ---------------------------------------------------------------
   localparam logic [3:0] ICODE_LOWEST = 4'h1;
   localparam logic [3:0] ICODE_STEPPED = 4'h4;
   localparam logic [3:0] ICODE_ZERO = 4'h0;
   localparam logic [9:0] EXT_MA_ZERO = 10'h000;
   localparam logic [9:0] EXT_MA_FACTORY = 10'h1F4; // 500 mA
   localparam logic [9:0] EXT_MA_CHARGER = 10'h230; // 560 mA
   localparam logic [9:0] EXT_MA_LPB = 10'h190; // 400 mA
   // ---------------------------------------------------------------
   // sequencer states, one-hot
   // ---------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_TRICKLE = 8'h02,
      ST_POWERUP = 8'h04,
      ST_STEPUP = 8'h08,
      ST_WATCHDOG = 8'h10,
      ST_ON = 8'h20,
      ST_FACTORY = 8'h40,
      ST_SHUTDOWN = 8'h80
   } cbmc_state_t;
endpackage

/* verilog/cbmc_thermal.sv */
// battery thermistor check and thermistor bias drive
`timescale 1ns/1ns
module cbmc_thermal
   import cbmc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_charger_input,
   input wire logic i_core_rail_ready,
   input wire logic i_thermistor_in_range,
   input wire logic i_die_cold,
   input wire logic i_thermal_check_disable,
   input wire logic i_bias_out_enable,
   output logic o_thermistor_bias_out,
   output logic o_temp_fault
);
   typedef struct packed {
      logic bias;
      logic fault;
   } cbmc_th_t;
   cbmc_th_t st_ff, nxt_st_ff;

   // ---------------------------------------------------------------
   // bias drive and out of range detection
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st_ff = st_ff;
      // auto bias wins over the enable bit unless the check is off
      nxt_st_ff.bias = i_bias_out_enable |
         (i_charger_input & i_core_rail_ready & ~i_thermal_check_disable);
      // die cold forces the wait state even with the check bypassed
      nxt_st_ff.fault = i_die_cold |
         (~i_thermal_check_disable & ~i_thermistor_in_range & i_charger_input);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st_ff;
      end
   end

   assign o_thermistor_bias_out = st_ff.bias;
   assign o_temp_fault = st_ff.fault;

   chk_cold_forces_fault: assert property (@(posedge i_core_clk) disable iff (i_reset)
      i_die_cold |=> o_temp_fault) else $error("cold die did not force fault");
endmodule

/* verilog/cbmc_top.sv */
// charger boot mode control: factory mode, low-power boot and thermal gating
// Operation
// - factory mode needs bus voltage and identity line pulled high at attach
// - serial factory: pass pair full on, isolation open, trickle, timers, limiter off
// - single factory: power application, minimum current, only charger timer and limiter off (trickle is also off in any factory mode)
// - override bit allows programming; software charge bit exits factory mode
// - mode strap low means normal boot, high permits low-power boot
// - boot flag set only with bus, low supply, strap high, serial path
// - flag clear, strap low: normal interrupt, turn on or trickle until threshold
// - flag clear, strap high, cold start: interrupt held low in watchdog phase
// - flag set: cold start with lowest current code, usb supplies on, indicator off
// - after power-up, before watchdog phase, raise current code to stepped value
// - drive interrupt high in watchdog phase; suppress other interrupts there
// - watchdog hold low or system reset in boot: shut down, trickle, clear flag
// - clearing boot interrupt lets other interrupts through; On mode behaves normally
// - boot acknowledge enables trickle and indicator; isolation closes above battery minimum
// - supply above on threshold in boot: leave trickle, clear flag, raise interrupt
// - charger input and core rail ready drive thermistor bias high
// - thermistor out of range: wait, pause timers, no battery current
// - out of range in precharge: 560/400 mA external, isolation open, trickle stop
// - other out of range: zero external current, isolation closed, then initialise
// - thermal check disable bypasses check and automatic bias drive
// - die below low limit always forces out of temperature state
// - in low-power boot, charger active flag waits for boot acknowledge
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
module cbmc_top
   import cbmc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   // avalon-mm slave
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // analog comparator results and pins
   input wire logic i_bus_valid,
   input wire logic i_identity_sense_line,
   input wire logic i_serial_path,
   input wire logic i_mode_strap,
   input wire logic i_supply_above_on,
   input wire logic i_supply_above_battery_on,
   input wire logic i_battery_above_min,
   input wire logic i_cold_start,
   input wire logic i_powerup_done,
   input wire logic i_watchdog_hold_input,
   input wire logic i_system_reset_n,
   input wire logic i_other_irq,
   input wire logic i_charger_input,
   input wire logic i_core_rail_ready,
   input wire logic i_thermistor_in_range,
   input wire logic i_die_cold,
   input wire logic i_precharge_active,
   // outputs
   output logic o_power_on,
   output logic o_processor_reset_out_n,
   output logic o_irq,
   output logic o_usb_supplies_en,
   output logic o_charge_indicator,
   output logic o_trickle_en,
   output logic o_pass_pair_full_on,
   output logic o_battery_isolation_closed,
   output logic o_charger_timer_en,
   output logic o_precharge_timer_en,
   output logic o_power_limiter_en,
   output logic [3:0] o_charge_current_code,
   output logic [9:0] o_ext_current_ma,
   output logic o_thermistor_bias_out
);
   typedef struct packed {
      cbmc_state_t state;
      logic [5:0] ctrl;
      logic boot_flag;
      logic boot_irq;
      logic bus_prev;
      logic factory;
      logic lpb_run;
      logic [3:0] icode;
      logic [31:0] rdata;
      logic ack;
   } cbmc_st_t;
   cbmc_st_t st_ff, nxt_st_ff;

   logic temp_fault;
   logic chg_active;
   logic lpb_cond;
   logic bus_access;

   // every check below runs on the core clock and rests during reset
   default clocking cb_core @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);

   // ---------------------------------------------------------------
   // thermistor check
   // ---------------------------------------------------------------
   cbmc_thermal u_thermal (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_charger_input(i_charger_input),
      .i_core_rail_ready(i_core_rail_ready),
      .i_thermistor_in_range(i_thermistor_in_range),
      .i_die_cold(i_die_cold),
      .i_thermal_check_disable(st_ff.ctrl[CTRL_THERM_DIS]),
      .i_bias_out_enable(st_ff.ctrl[CTRL_BIAS_EN]),
      .o_thermistor_bias_out(o_thermistor_bias_out),
      .o_temp_fault(temp_fault)
   );

   // qualification of a low-power boot; factory mode excludes it
   assign lpb_cond = i_bus_valid & ~st_ff.factory & ~i_supply_above_on &
      i_mode_strap & i_serial_path;
   assign bus_access = i_avs_read | i_avs_write;
   // active flag held back in boot until software acknowledges
   assign chg_active = ~(st_ff.lpb_run & ~st_ff.ctrl[CTRL_BOOT_ACK]);

   // ---------------------------------------------------------------
   // next state: bus, flags and sequencer
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st_ff = st_ff;
      nxt_st_ff.bus_prev = i_bus_valid;
      nxt_st_ff.ack = bus_access & ~st_ff.ack;
      nxt_st_ff.rdata = st_ff.rdata;
      // one wait state: answer on the second cycle of each request
      if (bus_access & ~st_ff.ack) begin
         if (i_avs_write && i_avs_address == CBMC_ADDR_CTRL) begin
            nxt_st_ff.ctrl = i_avs_writedata[5:0];
         end
         // the current code is writable only in factory mode with the override set
         if (i_avs_write && i_avs_address == CBMC_ADDR_CHG && st_ff.factory &&
             st_ff.ctrl[CTRL_OVERRIDE]) begin
            nxt_st_ff.icode = i_avs_writedata[3:0];
         end
         case (i_avs_address)
            CBMC_ADDR_CTRL: nxt_st_ff.rdata = {26'h0000000, st_ff.ctrl};
            CBMC_ADDR_STAT: nxt_st_ff.rdata = {16'h0000, st_ff.state, 3'h0,
               temp_fault, chg_active, st_ff.boot_irq, st_ff.boot_flag, st_ff.factory};
            CBMC_ADDR_CHG: nxt_st_ff.rdata = {28'h0000000, st_ff.icode};
            default: nxt_st_ff.rdata = 32'h00000000;
         endcase
      end
      // irq clear is a one-shot command bit
      if (st_ff.ctrl[CTRL_IRQ_CLR]) begin
         nxt_st_ff.ctrl[CTRL_IRQ_CLR] = 1'b0;
         nxt_st_ff.boot_irq = 1'b0;
      end
      // factory mode caught on the bus attach edge only
      if (i_bus_valid & ~st_ff.bus_prev) begin
         nxt_st_ff.factory = i_identity_sense_line;
      end
      if (~i_bus_valid) begin
         nxt_st_ff.factory = 1'b0;
      end
      if (st_ff.ctrl[CTRL_SW_CHARGE]) begin
         nxt_st_ff.factory = 1'b0;
      end
      case (st_ff.state)
         ST_IDLE: begin
            if (st_ff.factory) begin
               nxt_st_ff.state = ST_FACTORY;
            end else if (i_bus_valid & st_ff.bus_prev) begin
               // decided one cycle after attach, once the factory capture has landed
               nxt_st_ff.boot_flag = lpb_cond;
               nxt_st_ff.lpb_run = lpb_cond;
               if (lpb_cond) begin
                  nxt_st_ff.icode = ICODE_LOWEST;
                  nxt_st_ff.state = ST_POWERUP;
               end else if (i_supply_above_battery_on) begin
                  nxt_st_ff.state = ST_POWERUP;
               end else begin
                  nxt_st_ff.state = ST_TRICKLE;
               end
            end
         end
         ST_TRICKLE: begin
            // crossing the battery-on level is the turn-on event
            if (i_supply_above_battery_on) begin
               nxt_st_ff.state = ST_POWERUP;
            end
         end
         ST_POWERUP: begin
            if (i_powerup_done) begin
               nxt_st_ff.state = st_ff.lpb_run ? ST_STEPUP : ST_WATCHDOG;
            end
         end
         ST_STEPUP: begin
            nxt_st_ff.icode = ICODE_STEPPED;
            nxt_st_ff.state = ST_WATCHDOG;
         end
         ST_WATCHDOG: begin
            if (~st_ff.lpb_run | st_ff.ctrl[CTRL_BOOT_ACK]) begin
               nxt_st_ff.state = ST_ON;
            end
         end
         ST_ON: begin
            nxt_st_ff.state = ST_ON;
         end
         ST_FACTORY: begin
            if (~st_ff.factory) begin
               nxt_st_ff.state = ST_IDLE;
            end
         end
         ST_SHUTDOWN: begin
            // trickle recovery; wait for bus drop before a new attempt
            if (~i_bus_valid) begin
               nxt_st_ff.state = ST_IDLE;
            end
         end
         default: nxt_st_ff.state = ST_IDLE;
      endcase
      // supply above on threshold ends the boot and tells software
      if (st_ff.lpb_run & st_ff.boot_flag & i_supply_above_on) begin
         nxt_st_ff.boot_flag = 1'b0;
         nxt_st_ff.boot_irq = 1'b1;
         nxt_st_ff.lpb_run = 1'b0;
      end
      // failure of enumeration or a brownout tears the tree down
      if (st_ff.lpb_run && (st_ff.state == ST_WATCHDOG || st_ff.state == ST_ON) &&
          (~i_watchdog_hold_input | ~i_system_reset_n)) begin
         nxt_st_ff.state = ST_SHUTDOWN;
         nxt_st_ff.boot_flag = 1'b0;
         nxt_st_ff.lpb_run = 1'b0;
         nxt_st_ff.icode = ICODE_LOWEST;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         st_ff <= '{state: ST_IDLE, ctrl: CTRL_RESET, icode: ICODE_LOWEST, default: '0};
      end else begin
         st_ff <= nxt_st_ff;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic in_wd;
   logic in_fac;
   logic serial_fac;
   assign in_wd = (st_ff.state == ST_WATCHDOG);
   assign in_fac = (st_ff.state == ST_FACTORY);
   assign serial_fac = in_fac & i_serial_path;

   assign o_avs_waitrequest = bus_access & ~st_ff.ack;
   assign o_avs_readdata = st_ff.rdata;
   assign o_power_on = in_wd | (st_ff.state == ST_ON) | in_fac | (st_ff.state == ST_STEPUP) |
      (st_ff.state == ST_POWERUP);
   assign o_processor_reset_out_n = in_wd | (st_ff.state == ST_ON) | in_fac;
   // interrupt pin: boot forces high, strapped cold start forces low
   always_comb begin
      if (in_wd & st_ff.lpb_run) begin
         o_irq = 1'b1;
      end else if (in_wd & i_mode_strap & i_cold_start) begin
         o_irq = 1'b0;
      end else begin
         o_irq = st_ff.boot_irq | (i_other_irq & ~st_ff.boot_irq);
      end
   end
   assign o_usb_supplies_en = st_ff.lpb_run;
   assign o_charge_indicator = chg_active & ~in_fac & ~(st_ff.state == ST_SHUTDOWN);
   // trickle stops in factory and on any thermal wait
   assign o_trickle_en = ~in_fac & ~temp_fault & (st_ff.state == ST_TRICKLE |
      st_ff.state == ST_SHUTDOWN | (st_ff.lpb_run & st_ff.ctrl[CTRL_BOOT_ACK]));
   assign o_pass_pair_full_on = serial_fac;
   // isolation: open in serial factory, precharge wait and boot below battery minimum, closed otherwise
   always_comb begin
      if (serial_fac) begin
         o_battery_isolation_closed = 1'b0;
      end else if (temp_fault) begin
         o_battery_isolation_closed = ~i_precharge_active;
      end else if (st_ff.lpb_run) begin
         o_battery_isolation_closed = i_battery_above_min;
      end else begin
         o_battery_isolation_closed = 1'b1;
      end
   end
   // timers pause while temperature is out of range
   assign o_charger_timer_en = ~in_fac & ~temp_fault;
   assign o_precharge_timer_en = ~serial_fac & ~temp_fault;
   assign o_power_limiter_en = ~in_fac;
   assign o_charge_current_code = temp_fault ? ICODE_ZERO : st_ff.icode;
   always_comb begin
      if (temp_fault) begin
         if (~i_precharge_active) begin
            o_ext_current_ma = EXT_MA_ZERO;
         end else if (st_ff.lpb_run) begin
            o_ext_current_ma = EXT_MA_LPB;
         end else begin
            o_ext_current_ma = EXT_MA_CHARGER;
         end
      end else if (in_fac & ~i_serial_path) begin
         o_ext_current_ma = EXT_MA_FACTORY;
      end else begin
         o_ext_current_ma = EXT_MA_ZERO;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_powerup_done;
      (st_ff.state == ST_POWERUP) && i_powerup_done && st_ff.lpb_run;
   endsequence
   chk_stepup_before_wd: assert property (
      s_powerup_done ##1 (st_ff.state == ST_STEPUP) |=> st_ff.icode == ICODE_STEPPED)
      else $error("current code not stepped before watchdog");
   chk_boot_irq_high: assert property (
      (in_wd && st_ff.lpb_run) |-> o_irq) else $error("irq not high in boot");
   chk_wd_shutdown: assert property (
      (in_wd && st_ff.lpb_run && !i_watchdog_hold_input) |=>
      (st_ff.state == ST_SHUTDOWN && !st_ff.boot_flag)) else $error("no shutdown");
   chk_reset_shutdown: assert property (
      (st_ff.lpb_run && (in_wd || st_ff.state == ST_ON) && !i_system_reset_n) |=>
      (st_ff.state == ST_SHUTDOWN && !st_ff.lpb_run)) else $error("no shutdown on reset");
   chk_active_waits_ack: assert property (
      (st_ff.lpb_run && !st_ff.ctrl[CTRL_BOOT_ACK]) |-> !chg_active)
      else $error("active flag before ack");
   chk_boot_usb_on: assert property (
      (st_ff.lpb_run && !st_ff.ctrl[CTRL_BOOT_ACK]) |->
      (o_usb_supplies_en && !o_charge_indicator)) else $error("boot supplies wrong");

   // factory mode settings per path
   chk_factory_serial: assert property (
      serial_fac |-> (o_pass_pair_full_on && !o_battery_isolation_closed && !o_trickle_en))
      else $error("serial factory outputs wrong");
   chk_factory_single: assert property (
      (in_fac && !i_serial_path && !temp_fault) |-> (o_power_on && o_precharge_timer_en &&
      !o_charger_timer_en && !o_power_limiter_en && o_ext_current_ma == EXT_MA_FACTORY))
      else $error("single factory outputs wrong");
   chk_temp_no_current: assert property (
      temp_fault |-> (o_charge_current_code == ICODE_ZERO && !o_charger_timer_en))
      else $error("charging during thermal wait");
   chk_boot_flag_cond: assert property (
      (st_ff.state == ST_IDLE && !st_ff.factory && i_bus_valid && st_ff.bus_prev) |=>
      st_ff.boot_flag == $past(lpb_cond)) else $error("boot flag mismatch");
   chk_supply_on_irq: assert property (
      (st_ff.lpb_run && st_ff.boot_flag && i_supply_above_on) |=> st_ff.boot_irq)
      else $error("boot irq not raised");

   // pin level in a watchdog phase outside low-power boot
   chk_cold_irq_low: assert property (
      (in_wd && !st_ff.lpb_run && i_mode_strap && i_cold_start) |-> !o_irq)
      else $error("irq not held low on cold start");
   chk_warm_irq_normal: assert property (
      (in_wd && !st_ff.lpb_run && !i_cold_start && !st_ff.boot_irq) |-> o_irq == i_other_irq)
      else $error("irq not normal on warm start");
endmodule
